// [logic/dcd_pkg.sv]
//------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------
// Notes on behaviour
// [RULE_01] Carry stage pulses first carry output, then second, alternating.
// [RULE_02] Walking-code count decoded from two adjacent stage outputs.
// [RULE_03] Five-stage walking decade advances per pulse, clears on reset.
// [RULE_04] Match asserts when count equals selected preset position.
// [RULE_05] Programme step n on at decode n, off at decode n plus one.
// [RULE_06] Binary decade uses exactly four stages with complement outputs.
// [RULE_07] Binary decade counts 0 to 9 in 8-4-2-1, tenth pulse gives 0000.
// [RULE_08] Set steer high, clear steer low: stage goes to one.
// [RULE_09] Set steer low, clear steer high: stage goes to zero.
// [RULE_10] Both steers low: stage holds.
// [RULE_11] Steering never drives both steers high together.
// [RULE_12] Least significant stage toggles every pulse, dividing by two.
// [RULE_13] Second stage set steer is NOR of inverted A, B and D.
// [RULE_14] Second stage clear steer is NOR of inverted A and inverted B.
// [RULE_15] Third set steer and third clear steer share one NOR term.
// [RULE_16] After reset all walking stages are zero, complements one.
// [RULE_17] Stages set one to five in order, then clear one to five.
// [RULE_18] Walking stages advance on alternating divided phases.
// [RULE_19] Carry switches only on passing from count 9 to count 0.
// [RULE_20] Each count pulse is a one-cycle enable; all stages update together.
// [RULE_21] Reset forces all stages to zero and overrides counting.
package dcd_pkg;
    localparam int STAGES_WALK = 5;
    localparam int STAGES_BIN = 4;
    localparam int COUNT_W = 4;
    localparam int STEPS = 10;
    localparam logic [STAGES_WALK-1:0] WALK_RESET = 5'h00;
    localparam logic [STAGES_BIN-1:0] BIN_RESET = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_LAST = 4'h9;

    typedef struct packed {
        logic [STAGES_WALK-1:0] walk;
        logic phase;
        logic carry_mem;
        logic carry_sel;
        logic carry_a;
        logic carry_b;
        logic [STAGES_BIN-1:0] bin;
        logic [STEPS-1:0] prog;
        logic match;
    } dcd_state_t;

    typedef struct packed {
        logic [STEPS-1:0] onehot;
        logic [COUNT_W-1:0] value;
    } dcd_decode_t;
endpackage : dcd_pkg

// [logic/dcd_decade_counter.sv]
`timescale 1ns/1ps
module dcd_decade_counter (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_count,
    input wire logic i_clear,
    input wire logic [dcd_pkg::COUNT_W-1:0] i_preset,
    output logic [dcd_pkg::STAGES_WALK-1:0] o_walk,
    output logic [dcd_pkg::STAGES_WALK-1:0] o_walk_n,
    output logic [dcd_pkg::STEPS-1:0] o_decode,
    output logic [dcd_pkg::COUNT_W-1:0] o_walk_value,
    output logic o_carry_a,
    output logic o_carry_b,
    output logic o_carry_sel,
    output logic [dcd_pkg::STAGES_BIN-1:0] o_bin,
    output logic [dcd_pkg::STAGES_BIN-1:0] o_bin_n,
    output logic [dcd_pkg::STEPS-1:0] o_prog,
    output logic o_match,
    output logic o_phase
);
    //------------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------------
    // Pulse and clear come from outside, so each passes two flip-flops.
    logic [1:0] cnt_sync_r;
    logic [1:0] clr_sync_r;
    logic cnt_prev_r;
    logic cnt_pulse;
    logic clr_s;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_sync_r <= 2'h0;
            clr_sync_r <= 2'h0;
            cnt_prev_r <= 1'b0;
        end else begin
            cnt_sync_r <= {cnt_sync_r[0], i_count};
            clr_sync_r <= {clr_sync_r[0], i_clear};
            cnt_prev_r <= cnt_sync_r[1];
        end
    end

    // One rising edge becomes a single-cycle enable.
    assign cnt_pulse = cnt_sync_r[1] & ~cnt_prev_r; // see [RULE_20]
    assign clr_s = clr_sync_r[1];

    //------------------------------------------------------------------
    // Decode of the walking code
    //------------------------------------------------------------------
    dcd_pkg::dcd_state_t st_r;
    dcd_pkg::dcd_state_t st_nxt;
    dcd_pkg::dcd_decode_t dec;

    function automatic dcd_pkg::dcd_decode_t walk_decode(
        input logic [dcd_pkg::STAGES_WALK-1:0] w
    );
        dcd_pkg::dcd_decode_t d;
        d.onehot = '0;
        d.value = 4'h0;
        // Each count is identified by one adjacent pair only.
        d.onehot[0] = ~w[0] & ~w[4]; // see [RULE_02]
        d.onehot[5] = w[4] & w[0];
        for (int k = 0; k < 4; k++) begin
            d.onehot[k+1] = w[k] & ~w[k+1];
            d.onehot[k+6] = ~w[k] & w[k+1];
        end
        for (int k = 0; k < dcd_pkg::STEPS; k++) begin
            if (d.onehot[k]) begin
                d.value = 4'(k);
            end
        end
        return d;
    endfunction : walk_decode

    assign dec = walk_decode(st_r.walk);

    //------------------------------------------------------------------
    // Binary stage steering
    //------------------------------------------------------------------
    logic [dcd_pkg::STAGES_BIN-1:0] q;
    logic [dcd_pkg::STAGES_BIN-1:0] qn;
    logic [dcd_pkg::STAGES_BIN-1:0] m_st;
    logic [dcd_pkg::STAGES_BIN-1:0] n_st;
    logic qa_inv;
    logic shared_term;

    assign q = st_r.bin; // see [RULE_06]
    assign qn = ~st_r.bin;
    assign qa_inv = ~q[0];

    always_comb begin
        // Stage A divides by two.
        m_st[0] = qn[0]; // see [RULE_12]
        n_st[0] = q[0];
        m_st[1] = ~(qa_inv | q[1] | q[3]); // see [RULE_13]
        n_st[1] = ~(qa_inv | qn[1]); // see [RULE_14]
        // Set and clear of C share this term; they fire only at count 3 and 7 edges.
        shared_term = ~(qa_inv | qn[1]); // see [RULE_15]
        m_st[2] = ~(qa_inv | qn[1] | q[2]);
        n_st[2] = ~(qa_inv | qn[1] | qn[2]);
        n_st[3] = ~(qa_inv | qn[3]);
        m_st[3] = ~(qa_inv | qn[1] | qn[2] | q[3]);
        m_st[2] = m_st[2] & shared_term;
        n_st[2] = n_st[2] & shared_term;
    end

    function automatic logic steer(
        input logic cur,
        input logic m,
        input logic n
    );
        logic r;
        r = cur; // see [RULE_10]
        // The forbidden both-high case is excluded by the terms above.
        if (m && !n) begin // see [RULE_11]
            r = 1'b1; // see [RULE_08]
        end else if (!m && n) begin
            r = 1'b0; // see [RULE_09]
        end
        return r;
    endfunction : steer

    //------------------------------------------------------------------
    // State update
    //------------------------------------------------------------------
    logic [dcd_pkg::STAGES_WALK-1:0] w;
    logic [dcd_pkg::STAGES_WALK-1:0] wn;
    logic at_nine;

    always_comb begin
        st_nxt = st_r;
        w = st_r.walk;
        wn = st_r.walk;
        at_nine = (dec.value == dcd_pkg::COUNT_LAST);
        st_nxt.carry_a = 1'b0;
        st_nxt.carry_b = 1'b0;
        if (cnt_pulse) begin
            // Johnson step: shift in complement of stage five.
            wn = {w[3:0], ~w[4]}; // see [RULE_03] see [RULE_17]
            st_nxt.walk = wn;
            st_nxt.phase = ~st_r.phase; // see [RULE_18]
            if (at_nine) begin // see [RULE_19]
                st_nxt.carry_mem = ~st_r.carry_mem;
                st_nxt.carry_sel = ~st_r.carry_sel; // see [RULE_01]
                st_nxt.carry_a = ~st_r.carry_sel;
                st_nxt.carry_b = st_r.carry_sel;
            end
            for (int k = 0; k < dcd_pkg::STAGES_BIN; k++) begin
                st_nxt.bin[k] = steer(q[k], m_st[k], n_st[k]); // see [RULE_07]
            end
        end
        // Step k runs from decode k until decode k plus one.
        for (int k = 0; k < dcd_pkg::STEPS; k++) begin
            if (dec.onehot[(k + 1) % dcd_pkg::STEPS]) begin
                st_nxt.prog[k] = 1'b0; // see [RULE_05]
            end else if (dec.onehot[k]) begin
                st_nxt.prog[k] = 1'b1;
            end
        end
        st_nxt.match = (dec.value == i_preset); // see [RULE_04]
        if (clr_s) begin // see [RULE_21]
            st_nxt.walk = dcd_pkg::WALK_RESET;
            st_nxt.bin = dcd_pkg::BIN_RESET;
            st_nxt.phase = 1'b0;
            st_nxt.carry_mem = 1'b0;
            st_nxt.carry_sel = 1'b0;
            st_nxt.carry_a = 1'b0;
            st_nxt.carry_b = 1'b0;
            st_nxt.prog = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0; // see [RULE_16]
        end else begin
            st_r <= st_nxt;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign o_walk = st_r.walk;
    assign o_walk_n = ~st_r.walk;
    assign o_decode = dec.onehot;
    assign o_walk_value = dec.value;
    assign o_carry_a = st_r.carry_a;
    assign o_carry_b = st_r.carry_b;
    assign o_carry_sel = st_r.carry_sel;
    assign o_bin = st_r.bin;
    assign o_bin_n = ~st_r.bin;
    assign o_prog = st_r.prog;
    assign o_match = st_r.match;
    assign o_phase = st_r.phase;
endmodule : dcd_decade_counter

// [testbench/dcd_sva.sv]
`timescale 1ns/1ps
module dcd_sva (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_count,
    input wire logic i_clear,
    input wire logic [3:0] i_preset,
    input wire logic [4:0] o_walk,
    input wire logic [4:0] o_walk_n,
    input wire logic [9:0] o_decode,
    input wire logic [3:0] o_walk_value,
    input wire logic o_carry_a,
    input wire logic o_carry_b,
    input wire logic o_carry_sel,
    input wire logic [3:0] o_bin,
    input wire logic [3:0] o_bin_n,
    input wire logic [9:0] o_prog,
    input wire logic o_match,
    input wire logic o_phase
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_moved;
        !$stable(o_walk);
    endsequence
    // The count passes two sync stages and an edge detector first.
    sequence s_late;
        ##[3:4] s_moved;
    endsequence
    a_walk_pair: assert property (o_walk_n == ~o_walk)
        else $error("walk complement wrong");
    a_walk_step: assert property ($changed(o_walk) && o_walk != 5'h00 |->
        o_walk == {$past(o_walk[3:0]), ~$past(o_walk[4])})
        else $error("walk step wrong");
    a_decode_pair: assert property (
        o_decode == (10'h001 << o_walk_value))
        else $error("decode wrong");
    a_bin_same: assert property (
        o_bin == o_walk_value && o_bin_n == ~o_bin)
        else $error("binary decade wrong");
    a_carry_wrap: assert property (o_carry_a || o_carry_b |->
        o_walk == 5'h00 && $past(o_walk) == 5'h10)
        else $error("carry off the wrap");
    a_carry_alt: assert property (o_carry_a || o_carry_b |->
        o_carry_a == o_carry_sel && o_carry_a != o_carry_b)
        else $error("carry alternation wrong");
    a_prog_late: assert property (o_prog != 10'h000 |->
        o_prog == $past(o_decode))
        else $error("programme step wrong");
    a_match_late: assert property (o_match |->
        $past(o_walk_value) == $past(i_preset))
        else $error("match wrong");
    a_count_lat: assert property (
        $rose(i_count) && !i_clear |-> s_late)
        else $error("count not taken");
    a_phase_step: assert property (
        $changed(o_walk) && o_walk != 5'h00 |-> $changed(o_phase))
        else $error("phase did not alternate");
endmodule : dcd_sva
bind dcd_decade_counter dcd_sva u_sva (.i_ref_clk, .i_rst_n, .i_count,
    .i_clear, .i_preset, .o_walk, .o_walk_n, .o_decode, .o_walk_value,
    .o_carry_a, .o_carry_b, .o_carry_sel, .o_bin, .o_bin_n, .o_prog,
    .o_match, .o_phase);

// [testbench/dcd_pulse_src.sv]
`timescale 1ns/1ps
module dcd_pulse_src (
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic [7:0] i_num,
    output logic o_count,
    output logic o_busy
);
    int left = 0;
    int ph = 0;
    initial o_count = 1'b0;
    initial o_busy = 1'b0;
    // Three high and three low keeps every edge clear of the sync stages.
    always @(negedge i_clk) begin
        if (left == 0 && i_start) begin
            left = i_num;
            ph = 0;
        end
        if (left > 0) begin
            o_count <= (ph < 3);
            ph++;
            if (ph == 6) begin
                ph = 0;
                left--;
            end
        end
        o_busy <= (left > 0);
    end
endmodule : dcd_pulse_src

// [testbench/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, start = 1'b0;
    logic [3:0] preset = 4'h3;
    logic [7:0] num = 8'h00;
    logic cnt, busy, ca, cb, cs, match, phase;
    logic [4:0] walk, walk_n;
    logic [9:0] dec, prog;
    logic [3:0] wv, bin, bin_n;
    int err_count = 0, checks = 0, cyc = 0, n = 0, sel = 0;
    int ea = 0, eb = 0, na = 0, nb = 0, ep = 0;
    always #25 clk = ~clk;
    dcd_pulse_src u_src (.i_clk(clk), .i_start(start), .i_num(num),
        .o_count(cnt), .o_busy(busy));
    dcd_decade_counter u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_count(cnt), .i_clear(clr), .i_preset(preset), .o_walk(walk),
        .o_walk_n(walk_n), .o_decode(dec), .o_walk_value(wv),
        .o_carry_a(ca), .o_carry_b(cb), .o_carry_sel(cs), .o_bin(bin),
        .o_bin_n(bin_n), .o_prog(prog), .o_match(match), .o_phase(phase));
    task report_and_stop;
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (ca === 1'b1) na++;
        if (cb === 1'b1) nb++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    function automatic logic [4:0] walk_of(int k);
        if (k <= 5) return 5'((1 << k) - 1);
        return 5'(31 & ~((1 << (k - 5)) - 1));
    endfunction : walk_of
    task check_all;
        `CHK(walk, walk_of(n))
        `CHK(walk_n, ~walk_of(n))
        `CHK(dec, 10'(1 << n))
        `CHK(wv, 4'(n))
        `CHK(bin, 4'(n))
        `CHK(bin_n, ~4'(n))
        `CHK(prog, 10'(1 << n))
        `CHK(match, preset == 4'(n))
        `CHK(cs, sel[0])
        `CHK(na, ea)
        `CHK(nb, eb)
        `CHK(phase, ep[0])
    endtask : check_all
    task burst(int k);
        num <= 8'(k);
        start <= 1'b1;
        @(negedge clk);
        start <= 1'b0;
        do @(negedge clk); while (busy);
        repeat (6) @(negedge clk);
        repeat (k) begin
            n = (n + 1) % 10;
            ep ^= 1;
            if (n == 0 && sel == 0) ea++;
            else if (n == 0) eb++;
            if (n == 0) sel ^= 1;
        end
        check_all();
    endtask : burst
    task settle;
        repeat (6) @(negedge clk);
        n = 0;
        sel = 0;
        ep = 0;
        check_all();
    endtask : settle
    initial begin
        void'($urandom(32'hf77e));
        repeat (5) @(negedge clk);
        rst_n <= 1'b1;
        settle();
        $display("test reset done");
        burst(10);
        for (int i = 0; i < 12; i++) begin
            preset <= 4'($urandom_range(9));
            burst($urandom_range(25, 1));
        end
        $display("test random done");
        burst(7);
        clr <= 1'b1;
        repeat (4) @(negedge clk);
        clr <= 1'b0;
        settle();
        burst(13);
        $display("test clear done");
        rst_n <= 1'b0;
        repeat (5) @(negedge clk);
        rst_n <= 1'b1;
        settle();
        burst(19);
        $display("test rerun done");
        report_and_stop();
    end
endmodule : tb
